// File: verilog/dws_status_flags.sv
// Latched diagnostic and wake-up status flags with read-and-clear access.
// Assumes all event inputs are synchronous to clk_in; the serial front end
// supplies decoded reads and reports frame errors as one-cycle pulses.
//
// How it works
// - Clearable flags stay set until read-and-clear.
// - Drain-source faults set bits fifteen to twelve.
// - Bad command conditions set invalid-command bit.
// - Invalid frames are discarded, never executed.
// - Wrong clock count sets bit ten.
// - Pump low bit nine, thermal warning eight.
// - Regulator two short at turn-on bit seven.
// - Regulator fail events set bits six, five.
// - Bit four reserved; supply flags bits three-zero.
// - Wake sources latch bits 23, 20-17.
// - Debug mode latches bit sixteen.
// - Regulator one undervoltage sets bit fifteen.
// - Restart counter, self-clears after quiet minute.
// - Watchdog fail counter cleared by valid trigger.
// - State code in bits seven and six.
// - State code held until read-and-clear updates.
// - Thermal shutdown two bit five, one bit four.
// - Forced sleep thermal or short sets bit three.
// - Watchdog forced sleep bit two, failure bit one.
// - Power-on reset threshold sets bit zero.
`timescale 1ns/100ps
`default_nettype none
module dws_status_flags
    import dws_pkg::*;
#(
    parameter int     RESTART_W   = 3,
    parameter int     WDCNT_W     = 4,
    parameter longint QUIET_CYC   = RESTART_QUIET_CYC
) (
    // Clock and reset.
    input  wire logic              clk_in,
    input  wire logic              rst_b_in,
    // Decoded serial access.
    input  wire logic              frame_done_in,
    input  wire logic              frame_read_in,
    input  wire logic              frame_clear_in,
    input  wire logic [5:0]        frame_addr_in,
    input  wire logic              frame_undef_addr_in,
    input  wire logic              frame_bad_setting_in,
    input  wire logic              frame_parity_err_in,
    input  wire logic              frame_data_stuck_in,
    input  wire logic              frame_cs_timeout_in,
    input  wire logic              frame_clk_count_err_in,
    // Fault and supply events.
    input  wire logic [3:0]        ds_fault_in,
    input  wire logic              pump_low_in,
    input  wire logic              therm_warn_in,
    input  wire logic              reg2_short_in,
    input  wire logic              reg2_fail_in,
    input  wire logic              reg1_fail_in,
    input  wire logic [3:0]        supply_fault_in,
    // Wake and state events.
    input  wire logic [4:0]        wake_src_in,
    input  wire logic              debug_active_in,
    input  wire logic              reg1_uv_in,
    input  wire logic              restart_event_in,
    input  wire logic              wd_fail_in,
    input  wire logic              wd_valid_trig_in,
    input  wire logic [1:0]        cur_state_in,
    input  wire logic              thermal_shutdown_two_in,
    input  wire logic              thermal_shutdown_one_in,
    input  wire logic              fsleep_therm_in,
    input  wire logic              fsleep_wd_in,
    input  wire logic              por_level_in,
    // Read data and frame acceptance.
    output logic [REG_W-1:0]       read_data_out,
    output logic                   read_valid_out,
    output logic                   frame_exec_out
);

    ////////////////////////////////////////////////////////////////////////
    initial begin
        if (RESTART_W != 3 || WDCNT_W != 4 || QUIET_CYC < 1)
            $error("Counter widths must match the register layout.");
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame checks.
    logic [REG_W-1:0] fs_reg;
    logic [REG_W-1:0] ws_reg;
    logic [63:0]      quiet_cnt;

    // Any of these makes the frame invalid.
    wire status_write = frame_done_in & ~frame_read_in &
                        (frame_addr_in == ADDR_FAULT_SUPPLY || frame_addr_in == ADDR_WAKE_STATE);
    wire inv_cmd      = frame_undef_addr_in | status_write | frame_parity_err_in |
                        frame_data_stuck_in | frame_cs_timeout_in | frame_bad_setting_in;
    wire frame_ok     = frame_done_in & ~inv_cmd & ~frame_clk_count_err_in;
    wire hit_fs       = frame_ok & frame_read_in & (frame_addr_in == ADDR_FAULT_SUPPLY);
    wire hit_ws       = frame_ok & frame_read_in & (frame_addr_in == ADDR_WAKE_STATE);
    wire clr_fs       = hit_fs & frame_clear_in;
    wire clr_ws       = hit_ws & frame_clear_in;

    // Executed frames only; invalid frames are dropped.
    assign frame_exec_out = frame_ok;

    ////////////////////////////////////////////////////////////////////////
    // Fault and supply set vector.
    wire [REG_W-1:0] fs_set;
    assign fs_set[23:16]                   = 8'h00;
    assign fs_set[FS_DSMON_LO +: 4]        = ds_fault_in;
    assign fs_set[FS_INV_CMD]              = frame_done_in & inv_cmd;
    assign fs_set[FS_CLK_CNT]              = frame_clk_count_err_in;
    assign fs_set[FS_PUMP_LOW]             = pump_low_in;
    assign fs_set[FS_THERM_WARN]           = therm_warn_in;
    assign fs_set[FS_REG2_SHORT]           = reg2_short_in;
    assign fs_set[FS_REG2_FAIL]            = reg2_fail_in;
    assign fs_set[FS_REG1_FAIL]            = reg1_fail_in;
    assign fs_set[4]                       = 1'b0;
    assign fs_set[FS_MSUP_UV +: 4]         = supply_fault_in;

    // Wake and state set vector; counter and state fields are not flags.
    wire [REG_W-1:0] ws_set;
    assign ws_set[WS_EXT2_WAKE]            = wake_src_in[4];
    assign ws_set[22:21]                   = 2'h0;
    assign ws_set[WS_TMR_WAKE +: 4]        = wake_src_in[3:0];
    assign ws_set[WS_DEBUG]                = debug_active_in;
    assign ws_set[WS_REG1_UV]              = reg1_uv_in;
    assign ws_set[14:6]                    = 9'h000;
    assign ws_set[WS_THERMAL_SHUTDOWN_TWO]                 = thermal_shutdown_two_in;
    assign ws_set[WS_THERMAL_SHUTDOWN_ONE]                 = thermal_shutdown_one_in;
    assign ws_set[WS_FS_THERM]             = fsleep_therm_in;
    assign ws_set[WS_FS_WD]                = fsleep_wd_in;
    assign ws_set[WS_WD_FAIL]              = wd_fail_in;
    assign ws_set[WS_POR]                  = por_level_in;

    // Mask of clearable flag positions in the wake register.
    localparam logic [23:0] WS_FLAG_MASK = 24'h9f803f;

    // Set wins over clear in the same cycle.
    wire [REG_W-1:0] next_fs = (clr_fs ? 24'h000000 : fs_reg) | fs_set;
    wire [REG_W-1:0] ws_flags_next = ((clr_ws ? 24'h000000 : ws_reg) | ws_set) & WS_FLAG_MASK;

    ////////////////////////////////////////////////////////////////////////
    // Restart counter and its quiet window.
    wire [2:0] restart_cnt   = ws_reg[WS_RESTART_LO +: 3];
    wire       quiet_expired = (quiet_cnt >= 64'(QUIET_CYC - 1));
    wire [2:0] next_restart  = restart_event_in ? ((restart_cnt == 3'h7) ? restart_cnt : restart_cnt + 3'h1)
                             : (quiet_expired ? 3'h0 : restart_cnt);

    // Watchdog failure counter, saturating.
    wire [3:0] wd_cnt      = ws_reg[WS_WDCNT_LO +: 4];
    wire [3:0] next_wd_cnt = wd_valid_trig_in ? 4'h0
                           : (wd_fail_in && wd_cnt != 4'hf) ? wd_cnt + 4'h1 : wd_cnt;

    // State code held, refreshed from the live state on read-and-clear.
    wire [1:0] next_state = clr_ws ? ((cur_state_in == 2'h3) ? 2'h0 : cur_state_in)
                                   : ws_reg[WS_STATE_LO +: 2];

    wire [REG_W-1:0] next_ws;
    assign next_ws = ws_flags_next |
                     {9'h000, next_restart, next_wd_cnt, next_state, 6'h00};

    ////////////////////////////////////////////////////////////////////////
    // Register update.
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            fs_reg <= FS_RESET;
            ws_reg <= WS_RESET;
        end else begin
            fs_reg <= next_fs;
            ws_reg <= next_ws;
        end
    end

    // Quiet-time counter restarts on each restart event.
    always_ff @(posedge clk_in) begin
        if (!rst_b_in || restart_event_in || restart_cnt == 3'h0)
            quiet_cnt <= 64'h0;
        else if (!quiet_expired)
            quiet_cnt <= quiet_cnt + 64'h1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data captured before the clear takes effect.
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            read_data_out  <= 24'h000000;
            read_valid_out <= 1'b0;
        end else begin
            read_valid_out <= hit_fs | hit_ws;
            if (hit_fs)
                read_data_out <= fs_reg;
            else if (hit_ws)
                read_data_out <= ws_reg;
        end
    end

endmodule : dws_status_flags
`default_nettype wire

// File: pkg/dws_pkg.sv
// Constants for the latched diagnostic and wake-up status flag bank.
// Assumes a serial front end decodes frames and reports events as pulses.
package dws_pkg;
    // Register addresses as seen by the serial front end.
    localparam logic [5:0] ADDR_FAULT_SUPPLY = 6'h07;
    localparam logic [5:0] ADDR_WAKE_STATE   = 6'h08;
    localparam int         REG_W             = 24;

    // Fault and supply register field positions.
    localparam int FS_DSMON_LO   = 12;
    localparam int FS_INV_CMD    = 11;
    localparam int FS_CLK_CNT    = 10;
    localparam int FS_PUMP_LOW   = 9;
    localparam int FS_THERM_WARN = 8;
    localparam int FS_REG2_SHORT = 7;
    localparam int FS_REG2_FAIL  = 6;
    localparam int FS_REG1_FAIL  = 5;
    localparam int FS_RSUP_OV    = 3;
    localparam int FS_RSUP_UV    = 2;
    localparam int FS_MSUP_OV    = 1;
    localparam int FS_MSUP_UV    = 0;

    // Wake and state register field positions.
    localparam int WS_EXT2_WAKE  = 23;
    localparam int WS_EXT1_WAKE  = 20;
    localparam int WS_CAN_WAKE   = 19;
    localparam int WS_LIN_WAKE   = 18;
    localparam int WS_TMR_WAKE   = 17;
    localparam int WS_DEBUG      = 16;
    localparam int WS_REG1_UV    = 15;
    localparam int WS_RESTART_LO = 12;
    localparam int WS_WDCNT_LO   = 8;
    localparam int WS_STATE_LO   = 6;
    localparam int WS_THERMAL_SHUTDOWN_TWO       = 5;
    localparam int WS_THERMAL_SHUTDOWN_ONE       = 4;
    localparam int WS_FS_THERM   = 3;
    localparam int WS_FS_WD      = 2;
    localparam int WS_WD_FAIL    = 1;
    localparam int WS_POR        = 0;

    // Reset values.
    localparam logic [23:0] FS_RESET = 24'h000000;
    localparam logic [23:0] WS_RESET = 24'h000001;

    // Restart counter quiet window.
    localparam int  CLK_HZ           = 25000000;
    localparam int  RESTART_QUIET_S  = 60;
    localparam longint RESTART_QUIET_CYC = longint'(RESTART_QUIET_S) * longint'(CLK_HZ);

    // Operating state codes.
    typedef enum logic [1:0] {
        DWS_ST_ACTIVE_POR  = 2'h0,
        DWS_ST_WAKE_REG1   = 2'h1,
        DWS_ST_WAKE_BATT   = 2'h2
    } dws_state_t;
endpackage : dws_pkg

// File: tb/dws_host_model.sv
// Host model: issues decoded serial frames to the status bank and captures answers.
// Assumes the bank answers at the edge that takes a frame, ready 1 ns later.
`timescale 1ns/100ps
`default_nettype none
module dws_host_model (
    // Clock and answer from the bank.
    input  wire logic        clk_in,
    input  wire logic [23:0] rdata_in,
    input  wire logic        rvalid_in,
    // Frame request towards the bank.
    output var  logic        done_out,
    output var  logic        rd_out,
    output var  logic        clr_out,
    output var  logic [5:0]  addr_out,
    output var  logic [4:0]  bad_out
);
    // No frame is pending at time zero.
    initial {done_out, rd_out, clr_out, addr_out, bad_out} = '0;

    // One frame, held for one edge, then released with inverted qualifiers so stale values never pass.
    task xfer(input logic [1:0] rc, input logic [4:0] b, input logic [5:0] a, output logic [23:0] d, output logic v);
        @(posedge clk_in);
        {done_out, rd_out, clr_out, addr_out, bad_out} <= {1'b1, rc, a, b};
        @(posedge clk_in);
        {done_out, rd_out, clr_out, addr_out, bad_out} <= {1'b0, ~rc, ~a, 5'h0};
        #1;
        d = rdata_in;
        v = rvalid_in;
    endtask : xfer
endmodule : dws_host_model
`default_nettype wire

// File: tb/dws_status_flags_props.sv
// Checker for the read path, refusals and reserved fields of the status bank.
// Assumes it is bound to the bank and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module dws_status_flags_props
    import dws_pkg::*;
(
    input wire logic             clk_in,
    input wire logic             rst_b_in,
    input wire logic             frame_done_in,
    input wire logic             frame_read_in,
    input wire logic [5:0]       frame_addr_in,
    input wire logic             frame_parity_err_in,
    input wire logic             frame_cs_timeout_in,
    input wire logic [3:0]       ds_fault_in,
    input wire logic [4:0]       wake_src_in,
    input wire logic [REG_W-1:0] read_data_out,
    input wire logic             read_valid_out,
    input wire logic             frame_exec_out
);
    // All checks share one clock and its reset.
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    wire logic take = frame_done_in && frame_exec_out;
    property p_answer;
        take && frame_read_in && (frame_addr_in == ADDR_FAULT_SUPPLY || frame_addr_in == ADDR_WAKE_STATE)
            |=> read_valid_out;
    endproperty
    a_answer: assert property (p_answer) else $error("accepted frame gave no answer");
    property p_quiet; !take |=> !read_valid_out; endproperty
    a_quiet: assert property (p_quiet) else $error("answer without accepted frame");
    property p_refuse; frame_done_in && (frame_parity_err_in || frame_cs_timeout_in) |-> !frame_exec_out; endproperty
    a_refuse: assert property (p_refuse) else $error("bad frame was executed");
    property p_ds; ds_fault_in[3] ##1 (take && frame_addr_in == ADDR_FAULT_SUPPLY) |=> read_data_out[15]; endproperty
    a_ds: assert property (p_ds) else $error("switch fault flag missing");
    property p_wake; wake_src_in[4] ##1 (take && frame_addr_in == ADDR_WAKE_STATE) |=> read_data_out[23]; endproperty
    a_wake: assert property (p_wake) else $error("wake flag missing");
    property p_rsv7; read_valid_out && $past(frame_addr_in) == ADDR_FAULT_SUPPLY |-> !read_data_out[4]; endproperty
    a_rsv7: assert property (p_rsv7) else $error("reserved fault bit set");
    property p_rsv8; read_valid_out && $past(frame_addr_in) == ADDR_WAKE_STATE |-> read_data_out[22:21] == 2'h0; endproperty
    a_rsv8: assert property (p_rsv8) else $error("reserved wake bits set");
    property p_state; read_valid_out && $past(frame_addr_in) == ADDR_WAKE_STATE |-> read_data_out[7:6] != 2'h3; endproperty
    a_state: assert property (p_state) else $error("unused state code read");
endmodule : dws_status_flags_props
bind dws_status_flags dws_status_flags_props dws_status_flags_props_i (.clk_in, .rst_b_in, .frame_done_in,
    .frame_read_in,
    .frame_addr_in, .frame_parity_err_in, .frame_cs_timeout_in, .ds_fault_in, .wake_src_in, .read_data_out,
    .read_valid_out, .frame_exec_out);
`default_nettype wire

// File: tb/dws_status_flags_tb_top.sv
// Testbench for the status flag bank, driven through the host model.
// Assumes a short restart quiet window of 20 cycles.
`timescale 1ns/100ps
`default_nettype none
module dws_status_flags_tb_top;
    import dws_pkg::*;
    // Stimulus, event vectors laid out like the register bits, and bookkeeping.
    logic clk_in = 1'b0, rst_b_in = 1'b0, restart_event_in = 1'b0, wd_valid_trig_in = 1'b0;
    logic [1:0] cur_state_in = 2'h0, prev = 2'h0;
    logic [23:0] fsev = 24'h0, wsev = 24'h0, d;
    logic v;
    int failures = 0, cmp_count = 0;
    logic [5:0] row_addr [2] = '{ADDR_FAULT_SUPPLY, ADDR_WAKE_STATE};
    logic [23:0] row_mask [2] = '{24'h00f7ef, 24'h9f803d};
    wire logic frame_done_in, frame_read_in, frame_clear_in, frame_undef_addr_in, frame_bad_setting_in;
    wire logic frame_parity_err_in, frame_data_stuck_in, frame_cs_timeout_in, frame_clk_count_err_in;
    wire logic pump_low_in, therm_warn_in, reg2_short_in, reg2_fail_in, reg1_fail_in, debug_active_in;
    wire logic reg1_uv_in, thermal_shutdown_two_in, thermal_shutdown_one_in, fsleep_therm_in, fsleep_wd_in, wd_fail_in, por_level_in;
    wire logic read_valid_out, frame_exec_out;
    wire logic [3:0] ds_fault_in, supply_fault_in;
    wire logic [4:0] wake_src_in, bad;
    wire logic [5:0] frame_addr_in;
    wire logic [23:0] read_data_out;
    // Event vectors fan out to the bank's event inputs.
    assign {ds_fault_in, frame_clk_count_err_in, pump_low_in, therm_warn_in} = {fsev[15:12], fsev[10:8]};
    assign {reg2_short_in, reg2_fail_in, reg1_fail_in, supply_fault_in} = {fsev[7:5], fsev[3:0]};
    assign {wake_src_in, debug_active_in, reg1_uv_in} = {wsev[23], wsev[20:15]};
    assign {thermal_shutdown_two_in, thermal_shutdown_one_in, fsleep_therm_in, fsleep_wd_in, wd_fail_in, por_level_in} = wsev[5:0];
    assign {frame_undef_addr_in, frame_bad_setting_in, frame_parity_err_in, frame_data_stuck_in} = bad[4:1];
    assign frame_cs_timeout_in = bad[0];
    // Clock of 40 ns.
    always #20 clk_in = ~clk_in;
    dws_status_flags #(.QUIET_CYC(20)) dws_status_flags_i (.*);
    dws_host_model dws_host_model_i (.clk_in, .rdata_in(read_data_out), .rvalid_in(read_valid_out),
        .done_out(frame_done_in), .rd_out(frame_read_in), .clr_out(frame_clear_in), .addr_out(frame_addr_in),
        .bad_out(bad));
    ////////////////////////////////////////////////////////////////////////////////////////////////////
    // Compares a result word and counts the outcome.
    task chk(input logic [23:0] got, input logic [23:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Pulses an event one cycle ahead of a frame, then checks the answer.
    task op(input logic ws, input logic [23:0] ev, input logic [1:0] rc, input logic [4:0] b,
            input logic [5:0] a, input logic [23:0] exp, input logic ok);
        fork
            begin
                @(posedge clk_in);
                fsev <= ws ? 24'h0 : ev;
                wsev <= ws ? ev : 24'h0;
                @(posedge clk_in);
                fsev <= 24'h0;
                wsev <= 24'h0;
            end
            begin
                @(posedge clk_in);
                dws_host_model_i.xfer(rc, b, a, d, v);
            end
        join
        chk({23'h0, v}, {23'h0, ok});
        if (ok) chk(d, exp);
    endtask : op
    // Prints the verdict and ends the run.
    task end_of_test;
        if (failures == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    // Cuts a hang short.
    initial begin
        repeat (3000) @(posedge clk_in);
        failures++;
        end_of_test;
    end
    // Main sequence: reset, flag rows, refusals, counters, state codes, second reset.
    initial begin
        repeat (5) @(posedge clk_in);
        rst_b_in <= 1'b1;
        op(1, 0, 2'b10, 0, ADDR_WAKE_STATE, 24'h000001, 1);
        op(1, 0, 2'b11, 0, ADDR_WAKE_STATE, 24'h000001, 1);
        op(1, 0, 2'b10, 0, ADDR_WAKE_STATE, 24'h000000, 1);
        for (int r = 0; r < 2; r++)
            for (int b = 0; b < 24; b++)
                if (row_mask[r][b]) op(r[0], 24'h1 << b, 2'b11, 0, row_addr[r], 24'h1 << b, 1);
        for (int j = 0; j < 6; j++) begin
            op(0, 24'h1, {j < 5, 1'b1}, (j < 5) ? 5'h1 << j : 5'h0, (j == 4) ? 6'h09 : ADDR_FAULT_SUPPLY, 0, 0);
            op(0, 0, 2'b11, 0, ADDR_FAULT_SUPPLY, 24'h000801, 1);
        end
        for (int k = 1; k < 4; k++) op(1, 24'h2, 2'b10, 0, ADDR_WAKE_STATE, {12'h0, 4'(k), 8'h02}, 1);
        op(1, 0, 2'b11, 0, ADDR_WAKE_STATE, 24'h000302, 1);
        op(1, 0, 2'b11, 0, ADDR_WAKE_STATE, 24'h000300, 1);
        @(posedge clk_in);
        wd_valid_trig_in <= 1'b1;
        @(posedge clk_in);
        wd_valid_trig_in <= 1'b0;
        op(1, 0, 2'b10, 0, ADDR_WAKE_STATE, 24'h000000, 1);
        repeat (2) begin
            @(posedge clk_in);
            restart_event_in <= 1'b1;
            @(posedge clk_in);
            restart_event_in <= 1'b0;
        end
        op(1, 0, 2'b11, 0, ADDR_WAKE_STATE, 24'h002000, 1);
        repeat (30) @(posedge clk_in);
        op(1, 0, 2'b10, 0, ADDR_WAKE_STATE, 24'h000000, 1);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_in);
            cur_state_in <= 2'(k) ^ 2'h2;
            op(1, 0, 2'b11, 0, ADDR_WAKE_STATE, {16'h0, prev, 6'h0}, 1);
            prev = (cur_state_in == 2'h3) ? 2'h0 : cur_state_in;
        end
        op(1, 0, 2'b11, 0, ADDR_WAKE_STATE, {16'h0, prev, 6'h0}, 1);
        @(posedge clk_in);
        rst_b_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        rst_b_in <= 1'b1;
        op(0, 0, 2'b10, 0, ADDR_FAULT_SUPPLY, 24'h000000, 1);
        op(1, 0, 2'b10, 0, ADDR_WAKE_STATE, 24'h000001, 1);
        end_of_test;
    end
endmodule : dws_status_flags_tb_top
`default_nettype wire
